// ==== rtl/serial_mode_pkg.sv ====
// constants for the serial port mode and enable control block
package serial_mode_pkg;

    // register addresses in the processor data space
    localparam logic [15:0] ADDR_MODE       = 16'hff50;
    localparam logic [15:0] ADDR_RX_ERROR   = 16'hff51;
    localparam logic [15:0] ADDR_TX_STATUS  = 16'hff52;
    localparam logic [15:0] ADDR_RX_BUFFER  = 16'hff53;
    localparam logic [15:0] ADDR_AUX_CTRL   = 16'hff54;

    // reset values
    localparam logic [7:0]  MODE_RESET      = 8'h01;
    localparam logic [7:0]  RX_BUFFER_RESET = 8'hff;
    localparam logic [7:0]  ZERO_BYTE       = 8'h00;

    // mode register field positions
    localparam int MODE_CLK_EN_BIT  = 7;
    localparam int MODE_TX_EN_BIT   = 6;
    localparam int MODE_RX_EN_BIT   = 5;
    localparam int MODE_FRAME_MSB   = 4;

    // auxiliary control register field positions
    localparam int AUX_BRK_RX_BIT   = 7;
    localparam int AUX_BRK_TX_BIT   = 6;
    localparam int AUX_PLAIN_MSB    = 5;

    // reception error bits: parity, framing, overrun
    localparam int RX_ERR_WIDTH     = 3;
    // transmission status bits: buffer full, shift busy
    localparam int TX_ST_WIDTH      = 2;

    // operation clock divider: system clocks per operation clock enable
    localparam int OP_CLK_DIV       = 2;

endpackage : serial_mode_pkg

// ==== rtl/port_clock_gate.sv ====
// operation clock enable divider, held low while the port is powered down
`timescale 1ns/100ps
`default_nettype none

module port_clock_gate #(
    parameter int DIV = serial_mode_pkg::OP_CLK_DIV // system clocks per enable pulse
) (
    input  wire logic clk_sys,    // system clock
    input  wire logic rstn,       // async reset, active low
    input  wire logic run,        // port clock enable bit
    output logic      op_clk_en   // one-cycle operation clock enable
);

    localparam int CW = (DIV > 1) ? $clog2(DIV) : 1;

    logic [CW-1:0] count;
    wire           wrap;
    wire  [CW-1:0] next_count;

    // counter restarts from zero each time the port is powered up
    assign wrap       = (count == CW'(DIV - 1));
    assign next_count = (!run || wrap) ? '0 : count + CW'(1);

    // divider state
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            count <= '0;
        end else begin
            count <= next_count;
        end
    end

    // enable stays low while run is low, so the port logic sees a stopped clock
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            op_clk_en <= 1'b0;
        end else begin
            op_clk_en <= run && wrap;
        end
    end

endmodule // port_clock_gate

`default_nettype wire

// ==== rtl/uart_mode_enable_control.sv ====
// mode register and enable control for the second serial port
//
// What this block does
// - an 8-bit mode register governs clock gating, transmit, receive and frame options.
// - the mode register sits at FF50H, is read/write, and resets to 01H.
// - the mode register takes whole-byte writes and single-bit writes that touch one bit.
// - with the clock enable bit low the operation clock stops and port logic is held reset.
// - bit 6 enables transmission; when low the transmit logic is synchronously reset.
// - bit 5 enables reception; when low the receive logic is synchronously reset.
// - with the clock enable low the transmit pin is driven high and receive input seen high.
// - clearing the clock enable resets error status, transmit status, buffer, aux bits 7-6.
// - rewriting the mode register with the same value leaves ongoing traffic undisturbed.
// - the port is steered by twelve registers, five of them held here, the rest elsewhere.
`timescale 1ns/100ps
`default_nettype none

module uart_mode_enable_control #(
    parameter int DIV = serial_mode_pkg::OP_CLK_DIV // system clocks per operation clock
) (
    input  wire logic        clk_sys,             // system clock, 20 MHz
    input  wire logic        rstn,                // async reset, active low
    input  wire logic [15:0] cpu_addr,            // processor data address
    input  wire logic [7:0]  cpu_wdata,           // byte write data
    input  wire logic        cpu_wr,              // byte write strobe
    input  wire logic        cpu_bit_wr,          // single-bit write strobe
    input  wire logic [2:0]  cpu_bit_sel,         // bit index for a bit write
    input  wire logic        cpu_bit_val,         // value for a bit write
    input  wire logic        cpu_rd,              // read strobe
    output logic      [7:0]  cpu_rdata,           // read data, one cycle after cpu_rd
    input  wire logic        core_tx_out,         // serial data from transmit shifter
    input  wire logic        core_tx_buf_full,    // transmit buffer holds data
    input  wire logic        core_tx_busy,        // transmit shifter active
    input  wire logic        core_rx_valid,       // received byte strobe
    input  wire logic [7:0]  core_rx_data,        // received byte
    input  wire logic [2:0]  core_rx_err,         // parity, framing, overrun pulses
    input  wire logic        core_brk_rx,         // break field received pulse
    input  wire logic        core_brk_tx_done,    // break field sent pulse
    input  wire logic        serial_receive_pin,  // receive pin level
    output logic             serial_transmit_pin, // transmit pin level
    output logic             core_rx_in,          // receive level handed to the core
    output logic             port_clk_en,         // operation clock enable pulse
    output logic             port_rst_n,          // port logic reset, active low
    output logic             tx_sync_rst,         // transmit logic sync reset
    output logic             rx_sync_rst,         // receive logic sync reset
    output logic      [4:0]  frame_mode,          // frame option bits to the core
    output logic             break_transmit_trigger, // request a break field
    output logic      [5:0]  aux_ctrl             // plain aux control bits
);

    // merge a single-bit write into a byte
    function automatic logic [7:0] bit_merge(input logic [7:0] old, input logic [2:0] sel,
                                             input logic val);
        logic [7:0] res;
        res      = old;
        res[sel] = val;
        return res;
    endfunction

    logic [7:0] serial_port_mode_control;
    logic [serial_mode_pkg::RX_ERR_WIDTH-1:0] receive_error_status_reg;
    logic [serial_mode_pkg::TX_ST_WIDTH-1:0]  transmit_status_reg;
    logic [7:0] receive_buffer;
    logic       break_receive_flag;
    logic       brk_tx;
    logic [5:0] aux_plain;

    // address decode
    wire hit_mode = (cpu_addr == serial_mode_pkg::ADDR_MODE);
    wire hit_err  = (cpu_addr == serial_mode_pkg::ADDR_RX_ERROR);
    wire hit_txst = (cpu_addr == serial_mode_pkg::ADDR_TX_STATUS);
    wire hit_rxb  = (cpu_addr == serial_mode_pkg::ADDR_RX_BUFFER);
    wire hit_aux  = (cpu_addr == serial_mode_pkg::ADDR_AUX_CTRL);

    // mode field views
    wire port_clock_enable = serial_port_mode_control[serial_mode_pkg::MODE_CLK_EN_BIT];
    wire transmit_enable   = serial_port_mode_control[serial_mode_pkg::MODE_TX_EN_BIT];
    wire receive_enable    = serial_port_mode_control[serial_mode_pkg::MODE_RX_EN_BIT];
    wire powered_down      = !port_clock_enable;

    // next mode value: byte write replaces, bit write touches one bit only
    wire [7:0] next_mode =
        (cpu_wr && hit_mode)     ? cpu_wdata :
        (cpu_bit_wr && hit_mode) ? bit_merge(serial_port_mode_control,
                                             cpu_bit_sel, cpu_bit_val) :
                                   serial_port_mode_control;

    // mode register; reset leaves clock stopped and both directions off
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            serial_port_mode_control <= serial_mode_pkg::MODE_RESET;
        end else begin
            serial_port_mode_control <= next_mode;
        end
    end

    // aux register write view; bit 7 is set by the core and cleared by a write of zero
    wire [7:0] aux_view = {break_receive_flag, brk_tx, aux_plain};
    wire [7:0] aux_wr_val =
        (cpu_wr && hit_aux)     ? cpu_wdata :
        (cpu_bit_wr && hit_aux) ? bit_merge(aux_view, cpu_bit_sel, cpu_bit_val) :
                                  aux_view;
    wire aux_written = (cpu_wr || cpu_bit_wr) && hit_aux;

    // break trigger: software sets, hardware clears when the break is sent
    wire next_brk_tx = powered_down ? 1'b0 :
                       aux_written  ? aux_wr_val[serial_mode_pkg::AUX_BRK_TX_BIT] :
                       core_brk_tx_done ? 1'b0 : brk_tx;

    // break flag: hardware sets, a write of zero clears, set wins
    wire next_brk_rx = powered_down ? 1'b0 :
                       core_brk_rx  ? 1'b1 :
                       (aux_written && !aux_wr_val[serial_mode_pkg::AUX_BRK_RX_BIT]) ? 1'b0 :
                       break_receive_flag;

    // aux register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            brk_tx             <= 1'b0;
            break_receive_flag <= 1'b0;
            aux_plain          <= '0;
        end else begin
            brk_tx             <= next_brk_tx;
            break_receive_flag <= next_brk_rx;
            aux_plain          <= aux_wr_val[serial_mode_pkg::AUX_PLAIN_MSB:0];
        end
    end

    // error bits clear on read; a new error in the read cycle survives
    wire err_read = cpu_rd && hit_err;
    wire [serial_mode_pkg::RX_ERR_WIDTH-1:0] next_err =
        powered_down ? '0 :
        ((err_read ? '0 : receive_error_status_reg) | core_rx_err);

    // status mirrors cleared and receive buffer set to its reset value while powered down
    wire [serial_mode_pkg::TX_ST_WIDTH-1:0] next_txst =
        powered_down ? '0 : {core_tx_buf_full, core_tx_busy};
    wire [7:0] next_rxb =
        powered_down ? serial_mode_pkg::RX_BUFFER_RESET :
        core_rx_valid ? core_rx_data : receive_buffer;

    // status registers
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            receive_error_status_reg <= '0;
            transmit_status_reg      <= '0;
            receive_buffer           <= serial_mode_pkg::RX_BUFFER_RESET;
        end else begin
            receive_error_status_reg <= next_err;
            transmit_status_reg      <= next_txst;
            receive_buffer           <= next_rxb;
        end
    end

    // read mux; unmapped addresses read zero, the other seven port
    // registers live in the clock select, baud and pin blocks
    wire [7:0] next_rdata =
        !cpu_rd  ? cpu_rdata :
        hit_mode ? serial_port_mode_control :
        hit_err  ? {5'b0_0000, receive_error_status_reg} :
        hit_txst ? {6'b00_0000, transmit_status_reg} :
        hit_rxb  ? receive_buffer :
        hit_aux  ? aux_view : serial_mode_pkg::ZERO_BYTE;

    // read data register
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            cpu_rdata <= serial_mode_pkg::ZERO_BYTE;
        end else begin
            cpu_rdata <= next_rdata;
        end
    end

    // resets and enables follow mode levels only, so refreshing the
    // register with the same value makes no pulse on any of them
    wire next_tx_rst = powered_down || !transmit_enable;
    wire next_rx_rst = powered_down || !receive_enable;
    wire next_txd    = powered_down ? 1'b1 : core_tx_out;
    wire next_rxd    = powered_down ? 1'b1 : serial_receive_pin;

    // port control outputs, registered
    always_ff @(posedge clk_sys or negedge rstn) begin
        if (!rstn) begin
            port_rst_n             <= 1'b0;
            tx_sync_rst            <= 1'b1;
            rx_sync_rst            <= 1'b1;
            serial_transmit_pin    <= 1'b1;
            core_rx_in             <= 1'b1;
            frame_mode             <= serial_mode_pkg::MODE_RESET[4:0];
            break_transmit_trigger <= 1'b0;
            aux_ctrl               <= '0;
        end else begin
            port_rst_n             <= port_clock_enable;
            tx_sync_rst            <= next_tx_rst;
            rx_sync_rst            <= next_rx_rst;
            serial_transmit_pin    <= next_txd;
            core_rx_in             <= next_rxd;
            frame_mode             <= serial_port_mode_control[serial_mode_pkg::MODE_FRAME_MSB:0];
            break_transmit_trigger <= brk_tx;
            aux_ctrl               <= aux_plain;
        end
    end

    // operation clock enable, gated by the clock enable bit
    port_clock_gate #(
        .DIV       (DIV)
    ) u_clock_gate (
        .clk_sys   (clk_sys),
        .rstn      (rstn),
        .run       (port_clock_enable),
        .op_clk_en (port_clk_en)
    );

    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rstn);

    a_mode_byte_write: assert property (
        cpu_wr && hit_mode |=> serial_port_mode_control == $past(cpu_wdata))
        else $error("mode byte write not stored");

    a_mode_bit_write: assert property (
        cpu_bit_wr && !cpu_wr && hit_mode |=>
        serial_port_mode_control == bit_merge($past(serial_port_mode_control),
                                              $past(cpu_bit_sel), $past(cpu_bit_val)))
        else $error("bit write disturbed other mode bits");

    a_mode_read_back: assert property (
        cpu_rd && hit_mode |=> cpu_rdata == $past(serial_port_mode_control))
        else $error("mode register read back wrong");

    a_clock_held_off: assert property (
        powered_down |=> !port_rst_n ##0 !port_clk_en)
        else $error("port clock or reset active while powered down");

    a_tx_sync_reset: assert property (
        !transmit_enable && !$past(cpu_wr) |=> tx_sync_rst)
        else $error("transmit logic not reset while disabled");

    a_rx_sync_reset: assert property (
        port_clock_enable && receive_enable && !cpu_wr && !cpu_bit_wr [*2] |=> !rx_sync_rst)
        else $error("receive logic held reset while enabled");

    a_pins_idle_high: assert property (
        powered_down |=> serial_transmit_pin && core_rx_in)
        else $error("pins not forced high while powered down");

    a_status_cleared: assert property (
        powered_down |=> receive_error_status_reg == '0 && transmit_status_reg == '0
                         && receive_buffer == serial_mode_pkg::RX_BUFFER_RESET
                         && !break_receive_flag && !brk_tx)
        else $error("status not cleared while powered down");

    a_refresh_quiet: assert property (
        cpu_wr && hit_mode && cpu_wdata == serial_port_mode_control ##1 !cpu_wr && !cpu_bit_wr
        |=> $stable(port_rst_n) && $stable(tx_sync_rst) && $stable(rx_sync_rst))
        else $error("same-value rewrite disturbed the port");

    a_reset_state: assert property (
        $rose(rstn) |-> serial_port_mode_control == serial_mode_pkg::MODE_RESET
                        && !port_rst_n && tx_sync_rst && rx_sync_rst)
        else $error("port not idle after reset");

    // level-following outputs: the reset, pin and frame checks each catch a register stage
    // added or lost between the mode register and the port logic
    a_port_running: assert property (
        port_clock_enable |=> port_rst_n)
        else $error("port held in reset while clock enabled");

    a_clock_pulse_gap: assert property (
        port_clk_en && (DIV > 1) |=> !port_clk_en)
        else $error("operation clock enable longer than one cycle");

    a_tx_running: assert property (
        port_clock_enable && transmit_enable |=> !tx_sync_rst)
        else $error("transmit logic held reset while enabled");

    a_rx_held_off: assert property (
        !receive_enable |=> rx_sync_rst)
        else $error("receive logic not reset while disabled");

    a_tx_pin_follow: assert property (
        port_clock_enable |=> serial_transmit_pin == $past(core_tx_out))
        else $error("transmit pin lost the shifter data");

    a_rx_pin_follow: assert property (
        port_clock_enable |=> core_rx_in == $past(serial_receive_pin))
        else $error("receive level lost the pin data");

    a_frame_copy: assert property (
        1'b1 |=> frame_mode ==
                 $past(serial_port_mode_control[serial_mode_pkg::MODE_FRAME_MSB:0]))
        else $error("frame options not passed to the core");

    a_mode_hold: assert property (
        !((cpu_wr || cpu_bit_wr) && hit_mode) |=> $stable(serial_port_mode_control))
        else $error("mode register changed without a write");

    a_break_flag_set: assert property (
        core_brk_rx && port_clock_enable |=> break_receive_flag)
        else $error("break flag lost a received break");

    a_err_flag_set: assert property (
        port_clock_enable |=>
        (receive_error_status_reg & $past(core_rx_err)) == $past(core_rx_err))
        else $error("error status lost a reported error");

endmodule // uart_mode_enable_control

`default_nettype wire

// ==== dv/remote_station.sv ====
// remote serial station model driving the receive pin
`timescale 1ns/100ps
`default_nettype none

module remote_station (
    input  wire logic clk_sys,  // system clock
    input  wire logic active,   // frame in progress
    output logic      line_out  // level onto the receive pin
);
    // line level is unknown until the first falling edge; reset masks it
    logic [7:0] shreg = 8'ha6;

    // pattern goes out lsb first within frames; idle line sits high between them
    always @(negedge clk_sys) begin
        if (active) begin
            line_out <= shreg[0];
            shreg    <= {shreg[0], shreg[7:1]};
        end else begin
            line_out <= 1'b1;
            shreg    <= 8'ha6;
        end
    end
endmodule // remote_station

`default_nettype wire

// ==== dv/uart_mode_enable_control_tb_top.sv ====
// self-checking bench for the serial port mode and enable control
`timescale 1ns/100ps
`default_nettype none

module uart_mode_enable_control_tb_top;
    localparam int DIV_TB = 2;
    logic        clk_sys = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] cpu_addr = 16'h0000;
    logic [7:0]  cpu_wdata = 8'h00;
    logic [7:0]  core_rx_data = 8'h00;
    logic [7:0]  cpu_rdata;
    logic [2:0]  cpu_bit_sel = 3'h0;
    logic [2:0]  core_rx_err = 3'h0;
    logic [4:0]  frame_mode;
    logic [5:0]  aux_ctrl;
    logic        cpu_wr = 1'b0, cpu_bit_wr = 1'b0, cpu_bit_val = 1'b0, cpu_rd = 1'b0;
    logic        core_tx_out = 1'b1, core_tx_buf_full = 1'b0, core_tx_busy = 1'b0;
    logic        core_rx_valid = 1'b0, core_brk_rx = 1'b0, core_brk_tx_done = 1'b0;
    logic        serial_receive_pin, serial_transmit_pin, core_rx_in, port_clk_en;
    logic        port_rst_n, tx_sync_rst, rx_sync_rst, break_transmit_trigger;
    logic        frame_on = 1'b0;
    int          n_fail = 0;
    int          cmp_count = 0;

    uart_mode_enable_control #(.DIV(DIV_TB)) i_dut (
        .clk_sys, .rstn, .cpu_addr, .cpu_wdata, .cpu_wr, .cpu_bit_wr, .cpu_bit_sel,
        .cpu_bit_val, .cpu_rd, .cpu_rdata, .core_tx_out, .core_tx_buf_full, .core_tx_busy,
        .core_rx_valid, .core_rx_data, .core_rx_err, .core_brk_rx, .core_brk_tx_done,
        .serial_receive_pin, .serial_transmit_pin, .core_rx_in, .port_clk_en, .port_rst_n,
        .tx_sync_rst, .rx_sync_rst, .frame_mode, .break_transmit_trigger, .aux_ctrl);

    remote_station i_remote (.clk_sys(clk_sys), .active(frame_on), .line_out(serial_receive_pin));

    // 20 MHz system clock
    initial begin
        forever #25 clk_sys = ~clk_sys;
    end

    task automatic end_sim;
        $display("totals: %0d compares, %0d wrong", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    // one-cycle strobes, launched and dropped on falling edges
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_wdata = d;
        cpu_wr = 1'b1;
        @(negedge clk_sys);
        cpu_wr = 1'b0;
    endtask

    task automatic bwr(input logic [2:0] s, input logic v);
        @(negedge clk_sys);
        cpu_addr = serial_mode_pkg::ADDR_MODE;
        cpu_bit_sel = s;
        cpu_bit_val = v;
        cpu_bit_wr = 1'b1;
        @(negedge clk_sys);
        cpu_bit_wr = 1'b0;
    endtask

    // read data is registered, so it is looked at one cycle after the strobe
    task automatic rd(input logic [15:0] a, input logic [7:0] exp);
        @(negedge clk_sys);
        cpu_addr = a;
        cpu_rd = 1'b1;
        @(negedge clk_sys);
        cpu_rd = 1'b0;
        chk("read data", cpu_rdata, exp);
    endtask

    task automatic count_clk(input int n);
        int c;
        c = 0;
        repeat (4 * DIV_TB) begin
            @(posedge clk_sys);
            #1;
            if (port_clk_en === 1'b1) c++;
        end
        chk("clock pulses", 8'(c), 8'(n));
    endtask

    // a frame on both pins; each level is checked just after the rising edge that follows its launch
    task automatic pins(input logic pwr);
        frame_on = 1'b1;
        for (int k = 0; k < 6; k++) begin
            @(negedge clk_sys);
            core_tx_out = k[0];
            @(posedge clk_sys);
            #1;
            chk("tx pin", 8'(serial_transmit_pin), pwr ? 8'(k[0]) : 8'h01);
            chk("rx level", 8'(core_rx_in), pwr ? 8'(serial_receive_pin) : 8'h01);
            chk("port reset", 8'(port_rst_n), 8'(pwr));
            chk("tx reset", 8'(tx_sync_rst), 8'(!pwr));
        end
        frame_on = 1'b0;
    endtask

    // hang guard
    initial begin
        repeat (20000) @(posedge clk_sys);
        n_fail++;
        $display("run took too long");
        end_sim();
    end

    initial begin
        int i;
        repeat (5) @(posedge clk_sys);
        @(negedge clk_sys);
        rstn = 1'b1;
        rd(serial_mode_pkg::ADDR_MODE, serial_mode_pkg::MODE_RESET);
        chk("rx reset", 8'(rx_sync_rst), 8'h01);
        chk("frame", 8'(frame_mode), 8'h01);
        count_clk(0);
        pins(1'b0);
        $display("test reset done");
        wr(serial_mode_pkg::ADDR_MODE, 8'he0);
        rd(serial_mode_pkg::ADDR_MODE, 8'he0);
        chk("rx reset", 8'(rx_sync_rst), 8'h00);
        count_clk(4);
        pins(1'b1);
        $display("test power up done");
        // each frame bit set and cleared alone, the rest must hold
        for (i = 0; i < 5; i++) begin
            bwr(3'(i), 1'b1);
            rd(serial_mode_pkg::ADDR_MODE, 8'he0 | 8'(1 << i));
            chk("frame", 8'(frame_mode), 8'(1 << i));
            bwr(3'(i), 1'b0);
        end
        bwr(3'd6, 1'b0);
        rd(serial_mode_pkg::ADDR_MODE, 8'ha0);
        chk("tx reset", 8'(tx_sync_rst), 8'h01);
        chk("rx reset", 8'(rx_sync_rst), 8'h00);
        bwr(3'd6, 1'b1);
        bwr(3'd5, 1'b0);
        // reset outputs follow the mode register one cycle later
        @(negedge clk_sys);
        chk("rx reset", 8'(rx_sync_rst), 8'h01);
        chk("tx reset", 8'(tx_sync_rst), 8'h00);
        bwr(3'd5, 1'b1);
        $display("test bit writes done");
        // fill every status place, then power down
        wr(serial_mode_pkg::ADDR_AUX_CTRL, 8'h4c);
        @(negedge clk_sys);
        core_rx_err = 3'b111;
        core_rx_valid = 1'b1;
        core_rx_data = 8'h5a;
        core_brk_rx = 1'b1;
        core_tx_busy = 1'b1;
        core_tx_buf_full = 1'b1;
        @(negedge clk_sys);
        core_rx_err = 3'b010;
        core_rx_valid = 1'b0;
        core_brk_rx = 1'b0;
        @(negedge clk_sys);
        core_rx_err = 3'b000;
        rd(serial_mode_pkg::ADDR_RX_ERROR, 8'h07);
        rd(serial_mode_pkg::ADDR_TX_STATUS, 8'h03);
        rd(serial_mode_pkg::ADDR_RX_BUFFER, 8'h5a);
        rd(serial_mode_pkg::ADDR_AUX_CTRL, 8'hcc);
        chk("break trigger", 8'(break_transmit_trigger), 8'h01);
        @(negedge clk_sys);
        core_rx_err = 3'b001;
        @(negedge clk_sys);
        core_rx_err = 3'b000;
        wr(serial_mode_pkg::ADDR_MODE, 8'h60);
        rd(serial_mode_pkg::ADDR_RX_ERROR, 8'h00);
        rd(serial_mode_pkg::ADDR_TX_STATUS, 8'h00);
        rd(serial_mode_pkg::ADDR_RX_BUFFER, serial_mode_pkg::RX_BUFFER_RESET);
        rd(serial_mode_pkg::ADDR_AUX_CTRL, 8'h0c);
        chk("break trigger", 8'(break_transmit_trigger), 8'h00);
        chk("aux plain", 8'(aux_ctrl), 8'h0c);
        rd(16'hff55, 8'h00);
        core_tx_busy = 1'b0;
        core_tx_buf_full = 1'b0;
        $display("test power down done");
        // same value written again in mid-frame
        wr(serial_mode_pkg::ADDR_MODE, 8'he0);
        fork
            wr(serial_mode_pkg::ADDR_MODE, 8'he0);
            pins(1'b1);
        join
        count_clk(4);
        $display("test refresh done");
        // a finished break field takes the trigger down again
        wr(serial_mode_pkg::ADDR_AUX_CTRL, 8'h40);
        @(negedge clk_sys);
        chk("break trigger", 8'(break_transmit_trigger), 8'h01);
        core_brk_tx_done = 1'b1;
        @(negedge clk_sys);
        core_brk_tx_done = 1'b0;
        @(negedge clk_sys);
        chk("break trigger", 8'(break_transmit_trigger), 8'h00);
        $display("test break trigger done");
        end_sim();
    end
endmodule // uart_mode_enable_control_tb_top

`default_nettype wire
